// File: output_channel_config.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - with alignment enabled, divider restart waits the delay field in source-clock periods
// - alignment events are honoured only while the align-enable bit is one
// - muted outputs hold static: level 0 gives P low N high, 1 the reverse
// - silence bit one stops the clock at that level; zero lets it toggle
// - in CMOS formats polarity code inverts N, P or both independently
// - format field picks off, LVDS, HCSL, CML, LVPECL or CMOS variants; resets HCSL
// - route field sends channel one, own or channel three divider to the pins
// - clean-switch bit one applies route and divider-value changes glitch free, zero applies them at once
// - divider source code 0 prescaler A, 1 prescaler B, 3 reference
// - fourteen-bit divider divides its source; value zero powers it down
module output_channel_config (
	// clock and reset
	input  wire logic                     i_mclk,
	input  wire logic                     i_rst,
	// register port
	input  wire chan_cfg_pkg::reg_req_t   i_req,
	output logic [15:0]                   o_rdata,
	// source clocks, sampled from outside
	input  wire logic                     i_prescaler_a_clock,
	input  wire logic                     i_prescaler_b_clock,
	input  wire logic                     i_reference_clock,
	input  wire logic                     i_align_event,
	// neighbouring divider outputs
	input  wire logic                     i_chan_one_div_out,
	input  wire logic                     i_chan_three_div_out,
	// channel two pins and status
	output chan_cfg_pkg::diff_pair_t      o_pins,
	output logic [2:0]                    o_buffer_format,
	output logic                          o_low_supply_flag,
	output logic                          o_chan_three_div_out,
	output logic                          o_divider_powered
);
	import chan_cfg_pkg::*;

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [15:0] stage_q, stage_d;
	logic [15:0] misc_q, misc_d;
	logic [15:0] supply_q, supply_d;
	logic [15:0] rsvd_a_q, rsvd_a_d;
	logic [15:0] rsvd_b_q, rsvd_b_d;
	logic [15:0] divset_q, divset_d;
	logic [15:0] rdata_d;

	// write decode and read mux
	always_comb begin
		stage_d  = stage_q;
		misc_d   = misc_q;
		supply_d = supply_q;
		rsvd_a_d = rsvd_a_q;
		rsvd_b_d = rsvd_b_q;
		divset_d = divset_q;
		rdata_d  = 16'h0000;
		if (i_req.wr) begin
			case (i_req.addr)
				ADDR_OUTPUT_STAGE:   stage_d  = i_req.wdata;
				ADDR_MISC_SETTINGS:  misc_d   = i_req.wdata;
				ADDR_SUPPLY_SETTING: supply_d = i_req.wdata;
				ADDR_RSVD_WORD_A:    rsvd_a_d = i_req.wdata;
				ADDR_RSVD_WORD_B:    rsvd_b_d = i_req.wdata;
				ADDR_DIVIDER_SETUP:  divset_d = i_req.wdata;
				default:             ;
			endcase
		end
		if (i_req.rd) begin
			case (i_req.addr)
				ADDR_OUTPUT_STAGE:   rdata_d = stage_q;
				ADDR_MISC_SETTINGS:  rdata_d = misc_q;
				ADDR_SUPPLY_SETTING: rdata_d = supply_q;
				ADDR_RSVD_WORD_A:    rdata_d = rsvd_a_q;
				ADDR_RSVD_WORD_B:    rdata_d = rsvd_b_q;
				ADDR_DIVIDER_SETUP:  rdata_d = divset_q;
				default:             rdata_d = 16'h0000;
			endcase
		end
	end

	// register storage
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			stage_q  <= RST_OUTPUT_STAGE;
			misc_q   <= RST_MISC_SETTINGS;
			supply_q <= RST_SUPPLY_SETTING;
			rsvd_a_q <= RST_RSVD_WORD_A;
			rsvd_b_q <= RST_RSVD_WORD_B;
			divset_q <= RST_DIVIDER_SETUP;
			o_rdata  <= 16'h0000;
		end else begin
			stage_q  <= stage_d;
			misc_q   <= misc_d;
			supply_q <= supply_d;
			rsvd_a_q <= rsvd_a_d;
			rsvd_b_q <= rsvd_b_d;
			divset_q <= divset_d;
			o_rdata  <= rdata_d;
		end
	end

	// field views
	logic [4:0]  chan_two_align_delay;
	logic        chan_two_align_enable;
	logic        chan_two_silence_level;
	logic        chan_two_silence;
	logic [1:0]  chan_two_single_ended_polarity;
	logic [2:0]  chan_two_buffer_format;
	logic [1:0]  chan_two_route_select;
	logic        chan_two_clean_switch_enable;
	logic [1:0]  chan_three_divider_source;
	logic [13:0] chan_three_divider_value;

	assign chan_two_align_delay           = stage_q[ALIGN_DELAY_MSB:ALIGN_DELAY_LSB];
	assign chan_two_align_enable          = stage_q[ALIGN_ENABLE_BIT];
	assign chan_two_silence_level         = stage_q[SILENCE_LVL_BIT];
	assign chan_two_silence               = stage_q[SILENCE_BIT];
	assign chan_two_single_ended_polarity = stage_q[POLARITY_MSB:POLARITY_LSB];
	assign chan_two_buffer_format         = stage_q[FORMAT_MSB:FORMAT_LSB];
	assign chan_two_route_select          = stage_q[ROUTE_MSB:ROUTE_LSB];
	assign chan_two_clean_switch_enable   = misc_q[CLEAN_SWITCH_BIT];
	assign chan_three_divider_source      = divset_q[DIV_SOURCE_MSB:DIV_SOURCE_LSB];
	assign chan_three_divider_value       = divset_q[DIV_VALUE_MSB:DIV_VALUE_LSB];

	// ------------------------------------------------------------
	// input synchronisers: three stages, change when stages 2 and 3 agree
	// ------------------------------------------------------------
	localparam int NSYNC = 6;
	logic [NSYNC-1:0] sync_in;
	logic [NSYNC-1:0] sync_s1_q, sync_s2_q, sync_s3_q;
	logic [NSYNC-1:0] clean_q, clean_d;
	assign sync_in = {i_chan_three_div_out, i_chan_one_div_out, i_align_event,
		i_reference_clock, i_prescaler_b_clock, i_prescaler_a_clock};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			// filtered level update
			always_comb begin
				clean_d[gi] = clean_q[gi];
				if (sync_s2_q[gi] == sync_s3_q[gi]) begin
					clean_d[gi] = sync_s2_q[gi];
				end
			end
		end
	endgenerate

	// synchroniser chain
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sync_s1_q <= '0;
			sync_s2_q <= '0;
			sync_s3_q <= '0;
			clean_q   <= '0;
		end else begin
			sync_s1_q <= sync_in;
			sync_s2_q <= sync_s1_q;
			sync_s3_q <= sync_s2_q;
			clean_q   <= clean_d;
		end
	end

	// ------------------------------------------------------------
	// channel three divider source and edge detect
	// ------------------------------------------------------------
	logic src_lvl;
	logic src_prev_q, src_prev_d;
	logic src_rise;
	logic event_prev_q, event_prev_d;
	logic align_rise;
	// source select
	always_comb begin
		case (chan_three_divider_source)
			SRC_PRESCALER_A: src_lvl = clean_q[0];
			SRC_PRESCALER_B: src_lvl = clean_q[1];
			SRC_REFERENCE:   src_lvl = clean_q[2];
			default:         src_lvl = 1'b0;
		endcase
	end

	assign src_prev_d   = src_lvl;
	assign event_prev_d = clean_q[3];
	assign src_rise     = src_lvl & ~src_prev_q;
	assign align_rise   = clean_q[3] & ~event_prev_q;
	// ------------------------------------------------------------
	// divider with alignment delay
	// ------------------------------------------------------------
	typedef enum logic [1:0] {DIV_RUN, DIV_WAIT} div_state_t;
	div_state_t  div_st_q, div_st_d;
	logic [13:0] div_cnt_q, div_cnt_d;
	logic [4:0]  dly_cnt_q, dly_cnt_d;
	logic        div_out_q, div_out_d;
	logic [13:0] div_act_q, div_act_d;
	// divider next state
	always_comb begin
		div_st_d  = div_st_q;
		div_cnt_d = div_cnt_q;
		dly_cnt_d = dly_cnt_q;
		div_out_d = div_out_q;
		div_act_d = div_act_q;
		case (div_st_q)
			DIV_RUN: begin
				if (align_rise && chan_two_align_enable) begin
					div_st_d  = DIV_WAIT;
					dly_cnt_d = chan_two_align_delay;
					div_cnt_d = 14'h0000;
					div_out_d = 1'b0;
				end else if (div_act_q <= 14'h0001) begin
					div_out_d = src_lvl & div_act_q[0];
					div_cnt_d = 14'h0000;
					div_act_d = chan_three_divider_value;
				end else if (src_rise) begin
					// output high for the first half of the count
					if (div_cnt_q >= div_act_q - 14'h0001) begin
						div_cnt_d = 14'h0000;
						div_out_d = 1'b1;
						// new value taken at the period boundary when clean
						div_act_d = chan_three_divider_value;
					end else begin
						div_cnt_d = div_cnt_q + 14'h0001;
						div_out_d = (div_cnt_q + 14'h0001) < (div_act_q >> 1);
					end
				end
				if (!chan_two_clean_switch_enable) begin
					div_act_d = chan_three_divider_value;
				end
			end
			DIV_WAIT: begin
				if (dly_cnt_q == 5'h00) begin
					div_st_d  = DIV_RUN;
				end else if (src_rise) begin
					dly_cnt_d = dly_cnt_q - 5'h01;
				end
			end
			default: div_st_d = DIV_RUN;
		endcase
	end

	// divider registers
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			div_st_q     <= DIV_RUN;
			div_cnt_q    <= 14'h0000;
			dly_cnt_q    <= 5'h00;
			div_out_q    <= 1'b0;
			div_act_q    <= RST_DIVIDER_SETUP[DIV_VALUE_MSB:DIV_VALUE_LSB];
			src_prev_q   <= 1'b0;
			event_prev_q <= 1'b0;
		end else begin
			div_st_q     <= div_st_d;
			div_cnt_q    <= div_cnt_d;
			dly_cnt_q    <= dly_cnt_d;
			div_out_q    <= div_out_d;
			div_act_q    <= div_act_d;
			src_prev_q   <= src_prev_d;
			event_prev_q <= event_prev_d;
		end
	end

	// ------------------------------------------------------------
	// output route, mute, polarity and format
	// ------------------------------------------------------------
	logic [1:0] route_act_q, route_act_d;
	logic       route_lvl;
	logic       route_prev_q, route_prev_d;
	diff_pair_t pins_d;
	logic       low_boundary;
	// route candidate level
	always_comb begin
		case (route_act_q)
			ROUTE_CHAN_ONE:   route_lvl = clean_q[4];
			ROUTE_OWN:        route_lvl = div_out_q;
			ROUTE_CHAN_THREE: route_lvl = clean_q[5];
			default:          route_lvl = 1'b0;
		endcase
	end

	assign route_prev_d = route_lvl;
	assign low_boundary = ~route_lvl;
	// route switch: only while the output sits low when clean
	always_comb begin
		route_act_d = route_act_q;
		if (!chan_two_clean_switch_enable || low_boundary) begin
			route_act_d = chan_two_route_select;
		end
	end
	// pin levels
	always_comb begin
		pins_d.p = route_prev_q;
		pins_d.n = route_prev_q ^ (chan_two_buffer_format < FMT_CMOS_PN); // in phase for cmos
		if (chan_two_silence) begin
			pins_d.p = chan_two_silence_level;
			pins_d.n = ~chan_two_silence_level;
		end
		if (chan_two_buffer_format >= FMT_CMOS_PN) begin
			pins_d.p = pins_d.p ^ chan_two_single_ended_polarity[1];
			pins_d.n = pins_d.n ^ chan_two_single_ended_polarity[0];
			if (chan_two_buffer_format == FMT_CMOS_P) begin
				pins_d.n = 1'b0;
			end
			if (chan_two_buffer_format == FMT_CMOS_N) begin
				pins_d.p = 1'b0;
			end
		end
		if (chan_two_buffer_format == FMT_DISABLED) begin
			pins_d.p = 1'b0;
			pins_d.n = 1'b0;
		end
	end

	// output registers
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			route_act_q          <= RST_OUTPUT_STAGE[ROUTE_MSB:ROUTE_LSB];
			route_prev_q         <= 1'b0;
			o_pins               <= '0;
			o_buffer_format      <= RST_OUTPUT_STAGE[FORMAT_MSB:FORMAT_LSB];
			o_low_supply_flag    <= RST_SUPPLY_SETTING[LOW_SUPPLY_BIT];
			o_chan_three_div_out <= 1'b0;
			o_divider_powered    <= 1'b0;
		end else begin
			route_act_q          <= route_act_d;
			route_prev_q         <= route_prev_d;
			o_pins               <= pins_d;
			o_buffer_format      <= chan_two_buffer_format;
			o_low_supply_flag    <= supply_q[LOW_SUPPLY_BIT];
			o_chan_three_div_out <= div_out_q;
			o_divider_powered    <= (div_act_q != 14'h0000);
		end
	end

endmodule : output_channel_config

`default_nettype wire

// File: chan_cfg_pkg.sv
package chan_cfg_pkg;

	// ------------------------------------------------------------
	// register map (word addresses)
	// ------------------------------------------------------------
	localparam logic [7:0]  ADDR_OUTPUT_STAGE   = 8'h2C;
	localparam logic [7:0]  ADDR_MISC_SETTINGS  = 8'h2D;
	localparam logic [7:0]  ADDR_SUPPLY_SETTING = 8'h2E;
	localparam logic [7:0]  ADDR_RSVD_WORD_A    = 8'h2F;
	localparam logic [7:0]  ADDR_RSVD_WORD_B    = 8'h30;
	localparam logic [7:0]  ADDR_DIVIDER_SETUP  = 8'h31;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] RST_OUTPUT_STAGE    = 16'h0008;
	localparam logic [15:0] RST_MISC_SETTINGS   = 16'h0071;
	localparam logic [15:0] RST_SUPPLY_SETTING  = 16'h0008;
	localparam logic [15:0] RST_RSVD_WORD_A     = 16'h8000;
	localparam logic [15:0] RST_RSVD_WORD_B     = 16'h0000;
	localparam logic [15:0] RST_DIVIDER_SETUP   = 16'h0000;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ALIGN_DELAY_LSB  = 11;
	localparam int ALIGN_DELAY_MSB  = 15;
	localparam int ALIGN_ENABLE_BIT = 10;
	localparam int SILENCE_LVL_BIT  = 8;
	localparam int SILENCE_BIT      = 7;
	localparam int POLARITY_LSB     = 5;
	localparam int POLARITY_MSB     = 6;
	localparam int FORMAT_LSB       = 2;
	localparam int FORMAT_MSB       = 4;
	localparam int ROUTE_LSB        = 0;
	localparam int ROUTE_MSB        = 1;
	localparam int CLEAN_SWITCH_BIT = 0;
	localparam int LOW_SUPPLY_BIT   = 3;
	localparam int DIV_SOURCE_LSB   = 14;
	localparam int DIV_SOURCE_MSB   = 15;
	localparam int DIV_VALUE_LSB    = 0;
	localparam int DIV_VALUE_MSB    = 13;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [1:0]  SRC_PRESCALER_A = 2'h0;
	localparam logic [1:0]  SRC_PRESCALER_B = 2'h1;
	localparam logic [1:0]  SRC_REFERENCE   = 2'h3;
	localparam logic [1:0]  ROUTE_CHAN_ONE  = 2'h0;
	localparam logic [1:0]  ROUTE_OWN       = 2'h1;
	localparam logic [1:0]  ROUTE_CHAN_THREE = 2'h2;
	localparam logic [2:0]  FMT_DISABLED    = 3'h0;
	localparam logic [2:0]  FMT_CMOS_PN     = 3'h5;
	localparam logic [2:0]  FMT_CMOS_P      = 3'h6;
	localparam logic [2:0]  FMT_CMOS_N      = 3'h7;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic p;
		logic n;
	} diff_pair_t;

endpackage : chan_cfg_pkg

// File: output_channel_config_chk.sv
`timescale 1ns/1ps
`default_nettype none
module output_channel_config_chk (
	// watched ports
	input wire logic                     i_mclk,
	input wire logic                     i_rst,
	input wire chan_cfg_pkg::reg_req_t   i_req,
	input wire logic [15:0]              o_rdata,
	input wire chan_cfg_pkg::diff_pair_t o_pins,
	input wire logic [2:0]               o_buffer_format,
	input wire logic                     o_low_supply_flag,
	input wire logic                     o_chan_three_div_out,
	input wire logic                     o_divider_powered
);
	import chan_cfg_pkg::*;
	logic [15:0] stage_q, misc_q, supply_q, div_q, stage_d, misc_d, supply_d, div_d;
	logic [2:0]  settle_q, settle_d;
	logic        ok;
	logic [2:0]  fmt;
	// shadow registers and cycles since the last write
	always_comb begin
		stage_d  = stage_q;
		misc_d   = misc_q;
		supply_d = supply_q;
		div_d    = div_q;
		settle_d = (settle_q == 3'h7) ? settle_q : settle_q + 3'h1;
		if (i_req.wr) begin
			settle_d = 3'h0;
			case (i_req.addr)
				ADDR_OUTPUT_STAGE:   stage_d  = i_req.wdata;
				ADDR_MISC_SETTINGS:  misc_d   = i_req.wdata;
				ADDR_SUPPLY_SETTING: supply_d = i_req.wdata;
				ADDR_DIVIDER_SETUP:  div_d    = i_req.wdata;
				default: ;
			endcase
		end
	end
	// register the shadows
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			stage_q  <= RST_OUTPUT_STAGE;
			misc_q   <= RST_MISC_SETTINGS;
			supply_q <= RST_SUPPLY_SETTING;
			div_q    <= RST_DIVIDER_SETUP;
			settle_q <= 3'h0;
		end else begin
			stage_q  <= stage_d;
			misc_q   <= misc_d;
			supply_q <= supply_d;
			div_q    <= div_d;
			settle_q <= settle_d;
		end
	end
	assign ok  = (settle_q == 3'h7);
	assign fmt = stage_q[FORMAT_MSB:FORMAT_LSB];
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	sequence s_read_miss;
		i_req.rd && (i_req.addr < ADDR_OUTPUT_STAGE || i_req.addr > ADDR_DIVIDER_SETUP);
	endsequence
	sequence s_read_stage;
		i_req.rd && i_req.addr == ADDR_OUTPUT_STAGE;
	endsequence
	a_read_miss: assert property (s_read_miss |=> o_rdata == 16'h0000)
		else $error("unmapped read returned data");
	a_read_stage: assert property (s_read_stage |=> o_rdata == stage_q)
		else $error("output stage readback wrong");
	a_rdata_idle: assert property (!$past(i_req.rd) |-> o_rdata == 16'h0000)
		else $error("read data outside its cycle");
	a_format_out: assert property (ok |-> o_buffer_format == fmt)
		else $error("buffer format output wrong");
	a_disabled_low: assert property (ok && fmt == FMT_DISABLED |-> o_pins == 2'b00)
		else $error("disabled pins not low");
	a_mute_level: assert property (ok && stage_q[SILENCE_BIT] && fmt inside {[3'h1:3'h4]}
		|-> o_pins == {stage_q[SILENCE_LVL_BIT], !stage_q[SILENCE_LVL_BIT]})
		else $error("muted level wrong");
	a_supply_flag: assert property (ok |-> o_low_supply_flag == supply_q[LOW_SUPPLY_BIT])
		else $error("supply flag wrong");
	a_div_power: assert property (ok && !misc_q[CLEAN_SWITCH_BIT]
		|-> o_divider_powered == (div_q[DIV_VALUE_MSB:DIV_VALUE_LSB] != 14'h0))
		else $error("divider power state wrong");
	a_div_off: assert property (ok && !misc_q[CLEAN_SWITCH_BIT] && !o_divider_powered
		|-> !o_chan_three_div_out [*3])
		else $error("powered down divider toggles");
endmodule : output_channel_config_chk
bind output_channel_config output_channel_config_chk u_chk (.i_mclk, .i_rst, .i_req,
	.o_rdata, .o_pins, .o_buffer_format, .o_low_supply_flag, .o_chan_three_div_out,
	.o_divider_powered);
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import chan_cfg_pkg::*;
	logic        i_mclk, i_rst, i_align_event, i_chan_one_div_out, i_chan_three_div_out;
	reg_req_t    i_req;
	logic [15:0] o_rdata;
	diff_pair_t  o_pins;
	logic [2:0]  o_buffer_format;
	logic        o_low_supply_flag, o_chan_three_div_out, o_divider_powered, d3_q;
	logic [4:0]  tick_q = 5'h00;
	int          fail_count = 0;
	int          samples_checked = 0;
	output_channel_config u_dut (.i_mclk, .i_rst, .i_req, .o_rdata,
		.i_prescaler_a_clock (tick_q[2]),
		.i_prescaler_b_clock (tick_q[3]),
		.i_reference_clock   (tick_q[4]),
		.i_align_event, .i_chan_one_div_out, .i_chan_three_div_out, .o_pins,
		.o_buffer_format, .o_low_supply_flag, .o_chan_three_div_out, .o_divider_powered);
	// 100 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// source clocks of period 8, 16 and 32 cycles; last divider level
	always @(posedge i_mclk) begin
		tick_q <= tick_q + 5'h01;
		d3_q   <= o_chan_three_div_out;
	end
	// ------------------------------------------------------------
	// bus cycles and comparison
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_mclk);
		i_req <= '0;
		@(posedge i_mclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		i_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_mclk);
		i_req <= '0;
		#1 d = o_rdata;
		@(posedge i_mclk);
	endtask : rd
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// cycles until the next rising edge of the divider output
	task automatic rise(output int n);
		n = 0;
		do begin
			@(posedge i_mclk);
			#1 n++;
		end while (!(o_chan_three_div_out === 1'b1 && d3_q === 1'b0) && n < 600);
	endtask : rise
	task automatic complete_run;
		$display("checks=%0d errors=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		logic [15:0] v;
		logic [15:0] rv [6] = '{RST_OUTPUT_STAGE, RST_MISC_SETTINGS, RST_SUPPLY_SETTING,
			RST_RSVD_WORD_A, RST_RSVD_WORD_B, RST_DIVIDER_SETUP};
		chk({13'h0, o_buffer_format}, 16'h0002);
		chk({15'h0, o_low_supply_flag}, 16'h0001);
		for (int i = 0; i < 6; i++) begin
			rd(ADDR_OUTPUT_STAGE + 8'(i), v);
			chk(v, rv[i]);
			wr(ADDR_OUTPUT_STAGE + 8'(i), 16'h3C00 | 16'(i));
		end
		wr(8'h40, 16'hFFFF);
		rd(8'h40, v);
		chk(v, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			rd(ADDR_OUTPUT_STAGE + 8'(i), v);
			chk(v, 16'h3C00 | 16'(i));
			wr(ADDR_OUTPUT_STAGE + 8'(i), rv[i]);
		end
		wr(ADDR_OUTPUT_STAGE, 16'h0004);
		wr(ADDR_SUPPLY_SETTING, 16'h0000);
		#1 chk({13'h0, o_buffer_format}, 16'h0001);
		chk({15'h0, o_low_supply_flag}, 16'h0000);
		wr(ADDR_SUPPLY_SETTING, RST_SUPPLY_SETTING);
		wr(ADDR_OUTPUT_STAGE, RST_OUTPUT_STAGE);
	endtask : t_regs
	task automatic t_pins;
		logic [15:0] w [12] = '{16'h0008, 16'h000A, 16'h0009, 16'h0088, 16'h0188, 16'h0014,
			16'h0034, 16'h0054, 16'h0074, 16'h0018, 16'h001C, 16'h0000};
		logic [1:0] e [12] = '{2'h2, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1,
			2'h0};
		wr(ADDR_MISC_SETTINGS, 16'h0070);
		wr(ADDR_DIVIDER_SETUP, 16'h0000);
		foreach (w[i]) begin
			wr(ADDR_OUTPUT_STAGE, w[i]);
			repeat (8) @(posedge i_mclk);
			#1 chk({14'h0, o_pins}, {14'h0, e[i]});
			chk({13'h0, o_buffer_format}, {13'h0, w[i][4:2]});
		end
	endtask : t_pins
	task automatic t_divider;
		int n;
		logic [15:0] w [4] = '{16'h0004, 16'h4003, 16'hC002, 16'h0001};
		int p [4] = '{32, 48, 64, 8};
		foreach (w[i]) begin
			wr(ADDR_DIVIDER_SETUP, w[i]);
			repeat (3) rise(n);
			chk(16'(n), 16'(p[i]));
			chk({15'h0, o_divider_powered}, 16'h0001);
		end
		wr(ADDR_DIVIDER_SETUP, 16'h0000);
		repeat (4) @(posedge i_mclk);
		#1 chk({15'h0, o_divider_powered}, 16'h0000);
	endtask : t_divider
	task automatic t_clean;
		int run, low;
		wr(ADDR_MISC_SETTINGS, RST_MISC_SETTINGS);
		wr(ADDR_DIVIDER_SETUP, 16'h0004);
		repeat (2) rise(run);
		wr(ADDR_DIVIDER_SETUP, 16'h0002);
		run = -999;
		low = 999;
		repeat (200) begin
			@(posedge i_mclk);
			#1 run++;
			if (o_chan_three_div_out !== d3_q) begin
				if (run > 0 && run < low) low = run;
				run = 0;
			end
		end
		chk(16'(low >= 8), 16'h0001);
		repeat (2) rise(run);
		chk(16'(run), 16'h0010);
	endtask : t_clean
	task automatic t_align;
		int n;
		wr(ADDR_MISC_SETTINGS, 16'h0070);
		for (int en = 0; en < 2; en++) begin
			wr(ADDR_OUTPUT_STAGE, 16'hF808 | 16'(en << 10));
			repeat (2) rise(n);
			i_align_event <= 1'b1;
			repeat (6) @(posedge i_mclk);
			i_align_event <= 1'b0;
			rise(n);
			n = n + 6;
			chk(16'(en ? (n >= 252 && n <= 300) : (n <= 22)), 16'h0001);
		end
	endtask : t_align
	// main sequence
	initial begin
		i_rst                = 1'b1;
		i_req                = '0;
		i_align_event        = 1'b0;
		i_chan_one_div_out   = 1'b1;
		i_chan_three_div_out = 1'b0;
		repeat (6) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		t_regs();
		t_pins();
		t_divider();
		t_clean();
		t_align();
		complete_run();
	end
	// watchdog against a hang
	initial begin
		#300us;
		fail_count++;
		complete_run();
	end
endmodule : testbench
`default_nettype wire
